// File: hw/bldc_consts.svh
// register offsets, field positions, reset values and counts
// assumes a word-indexed register port with 16-bit data
`ifndef BLDC_CONSTS_SVH
`define BLDC_CONSTS_SVH

// register indices on the register port
`define OFF_TW_COUNT 5'h00
`define OFF_TW_CTRL 5'h01
`define OFF_TW_STATUS 5'h02
`define OFF_TW_IEN 5'h03
`define OFF_IO_SEL0 5'h04
`define OFF_IO_SEL1 5'h05
`define OFF_GR_A 5'h06
`define OFF_GR_B 5'h07
`define OFF_GR_C 5'h08
`define OFF_GR_D 5'h09
`define OFF_TV_COUNT 5'h0a
`define OFF_TV_CONST_A 5'h0b
`define OFF_TV_CONST_B 5'h0c
`define OFF_TV_CTRL0 5'h0d
`define OFF_TV_STATUS 5'h0e
`define OFF_TV_CTRL1 5'h0f
`define OFF_PORT_DATA 5'h10
`define OFF_PORT_DIR 5'h11

// capture timer control fields
`define TWC_CLK_LSB 0
`define TWC_CLR_A_BIT 2
`define TWC_RUN_BIT 7

// chopping control 0 fields
`define TV0_CLK_LSB 0
`define TV0_CLR_LSB 3
`define TV0_IEA_BIT 5
`define TV0_IEB_BIT 6

// chopping status fields
`define TVS_OUTA_LSB 2
`define TVS_OUTB_LSB 4

// reset values
`define RST_16 16'h0000
`define RST_8 8'h00
`define RST_GR 16'hffff

// prescaler length
`define PRESC_BITS 13

`endif

// File: hw/bldc_pkg.sv
// types for the commutation timer block
// assumes bldc_consts.svh for the numbers
package bldc_pkg;

  // output level action on a chopping match
  typedef enum logic [1:0] {
    OUT_KEEP = 2'b00,
    OUT_LOW = 2'b01,
    OUT_HIGH = 2'b10,
    OUT_TOGGLE = 2'b11
  } out_act_t;

  // whole state of the block
  typedef struct packed {
    logic [12:0] presc;
    logic [15:0] tw_cnt;
    logic [7:0] tw_ctl;
    logic [3:0] tw_flags;
    logic [3:0] tw_ien;
    logic [3:0] io_sel0;
    logic [7:0] io_sel1;
    logic [3:0][15:0] gr;
    logic [3:0] pin_prev;
    logic [3:0] tw_eq_prev;
    logic [2:0] ext_prev;
    logic [7:0] tv_cnt;
    logic [7:0] tv_ca;
    logic [7:0] tv_cb;
    logic [6:0] tv_ctl0;
    logic tv_ctl1;
    logic [1:0] tv_flags;
    logic [3:0] tv_osel;
    logic [1:0] tv_eq_prev;
    logic wave;
    logic [5:0] port_data;
    logic [5:0] port_oe_n;
    logic [15:0] rdata;
    logic irq_w;
    logic irq_v;
  } state_t;

endpackage

// File: hw/bldc_commutation_timers.sv
// capture/compare timer, chopping timer and phase port for a bldc drive
// assumes a cpu on a plain register port and synchronous pin inputs
//
// How it works
// - 13-bit prescaler counts every clock, giving divided ticks up to /128.
// - 16-bit capture counter, cpu read/write, clocked by /2, /4, /8 or external.
// - edge on input b, c or d copies counter to capture register, sets flag.
// - capture flag with its enable bit set raises the timer interrupt.
// - compare register a equal to counter sets flag a, interrupts if enabled.
// - select registers pick capture or compare per channel and capture edges.
// - 8-bit chopping counter, cpu read/write, clock from field plus select bit.
// - chopping counter cleared by external reset, match a or match b, selectable.
// - constants a and b compared with chopping counter, matches set flags.
// - chopping match flag with its enable bit set raises the chopping interrupt.
// - chopping compare held off in the cycle writing constant a or b.
// - chopping status holds flags and output level chosen per match a and b.
// - port bits 0 to 5 drive u, u inverse, v, v inverse, w, w inverse.
// - port read gives stored bit for outputs, live pin level for inputs.
// - direction register sets each pin input with 0, output with 1.
// - captures fire on rising, falling or both edges of rotor inputs, chosen per channel.
`timescale 1ns/1ps
`include "bldc_consts.svh"

module bldc_commutation_timers #(
  parameter int PRESC_W = 13
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [4:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_rotor_pos_in_b,
  input wire logic i_rotor_pos_in_c,
  input wire logic i_rotor_pos_in_d,
  input wire logic i_tw_ext_clk,
  input wire logic i_tv_ext_clk,
  input wire logic i_tv_ext_reset,
  input wire logic [5:0] i_phase_pin,
  output logic [5:0] o_phase_out,
  output logic [5:0] o_phase_oe_n,
  output logic o_chop_wave_out,
  output logic o_timer_irq,
  output logic o_chop_irq
);

  // the state struct fixes the prescaler length
  if (PRESC_W != `PRESC_BITS) begin : g_bad_presc
    $error("PRESC_W must equal the prescaler length");
  end

  bldc_pkg::state_t st;
  bldc_pkg::state_t nx;

  logic [3:0] pins;
  logic [3:0] tw_eq;
  logic [3:0] cap_ev;
  logic [3:0] cmp_ev;
  logic tw_tick;
  logic tv_tick;
  logic [7:0] tv_mask;
  logic tv_eq_a;
  logic tv_eq_b;
  logic tv_wr_const;
  logic tv_match_a;
  logic tv_match_b;
  logic tv_clr_match;
  logic tv_clr_ext;
  logic [5:0] port_read;

  // channel a has no pin
  assign pins = {i_rotor_pos_in_d, i_rotor_pos_in_c, i_rotor_pos_in_b, 1'b0};

  // per-channel capture and compare events
  for (genvar i = 0; i < 4; i++) begin : g_chan
    logic rise;
    logic fall;
    logic [1:0] edge_sel;
    assign rise = pins[i] & ~st.pin_prev[i];
    assign fall = ~pins[i] & st.pin_prev[i];
    assign edge_sel = st.io_sel1[2*i+1:2*i];
    assign tw_eq[i] = st.gr[i] == st.tw_cnt;
    // 00 rising, 01 falling, 1x both edges
    assign cap_ev[i] = st.io_sel0[i] & (edge_sel[1] ? (rise | fall) :
                       (edge_sel[0] ? fall : rise));
    assign cmp_ev[i] = ~st.io_sel0[i] & tw_eq[i] & ~st.tw_eq_prev[i];
  end

  // capture counter clock choice
  always_comb begin
    case (st.tw_ctl[`TWC_CLK_LSB +: 2])
      2'b00: tw_tick = st.presc[0];
      2'b01: tw_tick = &st.presc[1:0];
      2'b10: tw_tick = &st.presc[2:0];
      default: tw_tick = i_tw_ext_clk & ~st.ext_prev[0];
    endcase
    tw_tick = tw_tick & st.tw_ctl[`TWC_RUN_BIT];
  end

  // chopping clock: field 0 stops, else /2^field or external rising edge
  assign tv_mask = (8'h01 << st.tv_ctl0[`TV0_CLK_LSB +: 3]) - 8'h01;
  assign tv_tick = (st.tv_ctl0[`TV0_CLK_LSB +: 3] != 3'h0) &
                   (st.tv_ctl1 ? (i_tv_ext_clk & ~st.ext_prev[1]) :
                    (&(st.presc[7:0] | ~tv_mask)));

  // chopping compare, held off while a constant is written
  assign tv_wr_const = i_wr & ((i_addr == `OFF_TV_CONST_A) |
                       (i_addr == `OFF_TV_CONST_B));
  assign tv_eq_a = (st.tv_cnt == st.tv_ca) & ~tv_wr_const;
  assign tv_eq_b = (st.tv_cnt == st.tv_cb) & ~tv_wr_const;
  assign tv_match_a = tv_eq_a & ~st.tv_eq_prev[0];
  assign tv_match_b = tv_eq_b & ~st.tv_eq_prev[1];

  // clear source: 1 match a, 2 match b, 3 external reset
  assign tv_clr_match = ((st.tv_ctl0[`TV0_CLR_LSB +: 2] == 2'h1) & tv_eq_a) |
                        ((st.tv_ctl0[`TV0_CLR_LSB +: 2] == 2'h2) & tv_eq_b);
  assign tv_clr_ext = (st.tv_ctl0[`TV0_CLR_LSB +: 2] == 2'h3) &
                      i_tv_ext_reset & ~st.ext_prev[2];

  // stored bit for outputs, live pin for inputs
  assign port_read = (st.port_data & ~st.port_oe_n) |
                     (i_phase_pin & st.port_oe_n);

  // next-state logic
  always_comb begin
    logic [3:0] tw_clr;
    logic [1:0] tv_clr;
    logic [1:0] act;
    nx = st;
    tw_clr = 4'h0;
    tv_clr = 2'h0;
    act = 2'h0;
    nx.rdata = `RST_16;
    nx.presc = st.presc + 13'h0001;
    nx.pin_prev = pins;
    nx.ext_prev = {i_tv_ext_reset, i_tv_ext_clk, i_tw_ext_clk};
    nx.tw_eq_prev = tw_eq;
    nx.tv_eq_prev = {tv_eq_b, tv_eq_a};

    // capture counter, wraps at top; clear on compare a at the tick seen while equal,
    // since the one-cycle match pulse seldom lines up with a slow tick
    if (tw_tick) begin
      if (st.tw_ctl[`TWC_CLR_A_BIT] & ~st.io_sel0[0] & tw_eq[0]) begin
        nx.tw_cnt = `RST_16;
      end else begin
        nx.tw_cnt = st.tw_cnt + 16'h0001;
      end
    end

    // chopping counter
    if (tv_clr_ext) begin
      nx.tv_cnt = `RST_8;
    end else if (tv_tick) begin
      nx.tv_cnt = tv_clr_match ? `RST_8 : st.tv_cnt + 8'h01;
    end

    // chopping output, b applied after a
    if (tv_match_a) begin
      act = st.tv_osel[1:0];
      nx.wave = (act == 2'h3) ? ~nx.wave : ((act == 2'h0) ? nx.wave : act[1]);
    end
    if (tv_match_b) begin
      act = st.tv_osel[3:2];
      nx.wave = (act == 2'h3) ? ~nx.wave : ((act == 2'h0) ? nx.wave : act[1]);
    end

    // register writes
    if (i_wr) begin
      case (i_addr)
        `OFF_TW_COUNT: nx.tw_cnt = i_wdata;
        `OFF_TW_CTRL: nx.tw_ctl = i_wdata[7:0];
        `OFF_TW_STATUS: tw_clr = ~i_wdata[3:0];
        `OFF_TW_IEN: nx.tw_ien = i_wdata[3:0];
        `OFF_IO_SEL0: nx.io_sel0 = i_wdata[3:0];
        `OFF_IO_SEL1: nx.io_sel1 = i_wdata[7:0];
        `OFF_GR_A: nx.gr[0] = i_wdata;
        `OFF_GR_B: nx.gr[1] = i_wdata;
        `OFF_GR_C: nx.gr[2] = i_wdata;
        `OFF_GR_D: nx.gr[3] = i_wdata;
        `OFF_TV_COUNT: nx.tv_cnt = i_wdata[7:0];
        `OFF_TV_CONST_A: nx.tv_ca = i_wdata[7:0];
        `OFF_TV_CONST_B: nx.tv_cb = i_wdata[7:0];
        `OFF_TV_CTRL0: nx.tv_ctl0 = i_wdata[6:0];
        `OFF_TV_STATUS: begin
          tv_clr = ~i_wdata[1:0];
          nx.tv_osel = i_wdata[`TVS_OUTA_LSB +: 4];
        end
        `OFF_TV_CTRL1: nx.tv_ctl1 = i_wdata[0];
        `OFF_PORT_DATA: nx.port_data = i_wdata[5:0];
        `OFF_PORT_DIR: nx.port_oe_n = ~i_wdata[5:0];
        default: nx.rdata = `RST_16;
      endcase
    end

    // captures win over a cpu write
    for (int i = 0; i < 4; i++) begin
      if (cap_ev[i]) begin
        nx.gr[i] = st.tw_cnt;
      end
    end

    // sticky flags, set wins over clear
    nx.tw_flags = (st.tw_flags & ~tw_clr) | cap_ev | cmp_ev;
    nx.tv_flags = (st.tv_flags & ~tv_clr) | {tv_match_b, tv_match_a};

    // interrupt requests
    nx.irq_w = |(nx.tw_flags & nx.tw_ien);
    nx.irq_v = |(nx.tv_flags & {nx.tv_ctl0[`TV0_IEB_BIT],
               nx.tv_ctl0[`TV0_IEA_BIT]});

    // register reads, data in the next cycle only
    if (i_rd) begin
      case (i_addr)
        `OFF_TW_COUNT: nx.rdata = st.tw_cnt;
        `OFF_TW_CTRL: nx.rdata = {8'h00, st.tw_ctl};
        `OFF_TW_STATUS: nx.rdata = {12'h000, st.tw_flags};
        `OFF_TW_IEN: nx.rdata = {12'h000, st.tw_ien};
        `OFF_IO_SEL0: nx.rdata = {12'h000, st.io_sel0};
        `OFF_IO_SEL1: nx.rdata = {8'h00, st.io_sel1};
        `OFF_GR_A: nx.rdata = st.gr[0];
        `OFF_GR_B: nx.rdata = st.gr[1];
        `OFF_GR_C: nx.rdata = st.gr[2];
        `OFF_GR_D: nx.rdata = st.gr[3];
        `OFF_TV_COUNT: nx.rdata = {8'h00, st.tv_cnt};
        `OFF_TV_CONST_A: nx.rdata = {8'h00, st.tv_ca};
        `OFF_TV_CONST_B: nx.rdata = {8'h00, st.tv_cb};
        `OFF_TV_CTRL0: nx.rdata = {9'h000, st.tv_ctl0};
        `OFF_TV_STATUS: nx.rdata = {10'h000, st.tv_osel, st.tv_flags};
        `OFF_TV_CTRL1: nx.rdata = {15'h0000, st.tv_ctl1};
        `OFF_PORT_DATA: nx.rdata = {10'h000, port_read};
        `OFF_PORT_DIR: nx.rdata = {10'h000, ~st.port_oe_n};
        default: nx.rdata = `RST_16;
      endcase
    end
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      st <= '0;
      st.gr <= {4{`RST_GR}};
      st.port_oe_n <= 6'h3f;
    end else begin
      st <= nx;
    end
  end

  // outputs straight from the state
  assign o_rdata = st.rdata;
  assign o_phase_out = st.port_data;
  assign o_phase_oe_n = st.port_oe_n;
  assign o_chop_wave_out = st.wave;
  assign o_timer_irq = st.irq_w;
  assign o_chop_irq = st.irq_v;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  AST_PRESC_COUNTS: assert property (
    $past(i_resetn) |-> st.presc == $past(st.presc) + 13'h0001)
    else $error("prescaler does not step by one");

  AST_CAPTURE_B: assert property (
    cap_ev[1] |=> st.gr[1] == $past(st.tw_cnt) && st.tw_flags[1])
    else $error("capture b lost counter value or flag");

  AST_TW_IRQ: assert property (
    (cap_ev[2] && st.tw_ien[2] && !(i_wr && i_addr == `OFF_TW_IEN))
    |=> o_timer_irq)
    else $error("capture c flag did not raise interrupt");

  AST_COMPARE_A: assert property (
    (!st.io_sel0[0] && st.gr[0] == st.tw_cnt && !st.tw_eq_prev[0])
    |=> st.tw_flags[0])
    else $error("compare a match did not set flag");

  AST_WRAP: assert property (
    (tw_tick && st.tw_cnt == 16'hffff && !i_wr && !cmp_ev[0])
    |=> st.tw_cnt == 16'h0000)
    else $error("capture counter did not wrap to zero");

  AST_CHOP_CLEAR_A: assert property (
    (tv_tick && tv_eq_a && st.tv_ctl0[`TV0_CLR_LSB +: 2] == 2'h1 && !i_wr)
    |=> st.tv_cnt == 8'h00)
    else $error("chopping counter not cleared on match a");

  AST_CHOP_FLAG_B: assert property (
    tv_match_b |=> st.tv_flags[1])
    else $error("match b did not set flag");

  AST_CHOP_IRQ: assert property (
    (st.tv_flags[0] && st.tv_ctl0[`TV0_IEA_BIT] && !i_wr) |=> o_chop_irq)
    else $error("chopping interrupt missing");

  AST_NO_MATCH_ON_WRITE: assert property (
    (i_wr && (i_addr == `OFF_TV_CONST_A || i_addr == `OFF_TV_CONST_B))
    |=> st.tv_flags == $past(st.tv_flags) && $stable(o_chop_wave_out))
    else $error("chopping compare ran during constant write");

  AST_WAVE_HIGH_A: assert property (
    (tv_match_a && !tv_match_b && st.tv_osel[1:0] == 2'h2)
    |=> o_chop_wave_out)
    else $error("chopping output not high after match a");

  AST_PORT_READ: assert property (
    (i_rd && i_addr == `OFF_PORT_DATA) |=>
    o_rdata[5:0] == (($past(st.port_data) & ~$past(st.port_oe_n)) |
                     ($past(i_phase_pin) & $past(st.port_oe_n))))
    else $error("port read mixes data and pins wrongly");

  AST_PORT_DIR: assert property (
    (i_wr && i_addr == `OFF_PORT_DIR) |=> o_phase_oe_n == ~$past(i_wdata[5:0]))
    else $error("direction write not applied");

  AST_PORT_HOLD: assert property (
    !(i_wr && i_addr == `OFF_PORT_DATA) |=> $stable(o_phase_out))
    else $error("port output data changed without a data write");

  AST_CAPTURE_BOTH: assert property (
    (st.io_sel0[1] && st.io_sel1[3] && i_rotor_pos_in_b != st.pin_prev[1])
    |=> st.tw_flags[1])
    else $error("edge on input b in both-edge mode not flagged");

  AST_COMPARE_CLEAR: assert property (
    (tw_tick && st.tw_ctl[`TWC_CLR_A_BIT] && !st.io_sel0[0] &&
     st.gr[0] == st.tw_cnt && !i_wr)
    |=> st.tw_cnt == 16'h0000)
    else $error("capture counter not cleared on compare a");

  AST_CHOP_EXT_CLEAR: assert property (
    (st.tv_ctl0[`TV0_CLR_LSB +: 2] == 2'h3 && i_tv_ext_reset && !st.ext_prev[2] && !i_wr)
    |=> st.tv_cnt == 8'h00)
    else $error("chopping counter not cleared by external reset");

  AST_CHOP_STOPPED: assert property (
    (st.tv_ctl0[`TV0_CLK_LSB +: 3] == 3'h0 && st.tv_ctl0[`TV0_CLR_LSB +: 2] != 2'h3 && !i_wr)
    |=> $stable(st.tv_cnt))
    else $error("chopping counter moved with its clock stopped");

endmodule // bldc_commutation_timers

// File: verif/motor_side_model.sv
// motor side: driver pin levels, low-side gating and hall sensors
// assumes the bench pulses i_step once per 60 degree rotor step
`timescale 1ns/1ps
module motor_side_model (
  input wire logic i_clk,
  input wire logic i_step,
  input wire logic [5:0] i_float,
  input wire logic [5:0] i_phase_out,
  input wire logic [5:0] i_phase_oe_n,
  input wire logic i_chop,
  output logic [5:0] o_pin,
  output logic [2:0] o_hall,
  output logic [2:0] o_low_gate
);
  logic [2:0] pos = 3'h0;
  logic [5:0][2:0] seq;
  // six hall states, one line changes per step
  assign seq = {3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
  always @(posedge i_clk) begin
    if (i_step) begin
      pos <= (pos == 3'h5) ? 3'h0 : pos + 3'h1;
    end
  end
  assign o_hall = seq[pos];
  // undriven pins follow the level the far side puts on them
  assign o_pin = (i_phase_out & ~i_phase_oe_n) | (i_float & i_phase_oe_n);
  // low side switches get inverse phases anded with chopping
  assign o_low_gate = {i_phase_out[5], i_phase_out[3], i_phase_out[1]} & {3{i_chop}};
endmodule // motor_side_model

// File: verif/test_bldc_commutation_timers.sv
// self-checking bench for the commutation timer block
// assumes the motor side model drives pins and hall lines
`timescale 1ns/1ps
module test_bldc_commutation_timers;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic step = 1'b0;
  logic [5:0] float_lvl = 6'h00;
  logic [2:0] ext_in = 3'h0;
  logic [15:0] rdata;
  logic [15:0] d;
  logic [5:0] pout;
  logic [5:0] poe_n;
  logic [5:0] pin;
  logic [2:0] hall;
  logic wave;
  logic tirq;
  logic cirq;
  int n;
  int miscompares = 0;
  int num_checks = 0;

  bldc_commutation_timers bldc_commutation_timers_i (.i_clk(clk), .i_resetn(resetn),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_rotor_pos_in_b(hall[0]), .i_rotor_pos_in_c(hall[1]), .i_rotor_pos_in_d(hall[2]),
    .i_tw_ext_clk(ext_in[0]), .i_tv_ext_clk(ext_in[1]), .i_tv_ext_reset(ext_in[2]),
    .i_phase_pin(pin), .o_phase_out(pout), .o_phase_oe_n(poe_n),
    .o_chop_wave_out(wave), .o_timer_irq(tirq), .o_chop_irq(cirq));
  motor_side_model motor_side_model_i (.i_clk(clk), .i_step(step), .i_float(float_lvl),
    .i_phase_out(pout), .i_phase_oe_n(poe_n), .i_chop(wave), .o_pin(pin),
    .o_hall(hall), .o_low_gate());

  // 125 MHz clock
  always #4 clk = ~clk;

  task automatic tally_and_finish();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bounded wait for a level, counting the edges it took
  task automatic wait_lvl(ref logic s, input logic v, output int cnt);
    cnt = 0;
    while (s !== v && cnt < 200) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    if (s !== v) begin
      chk({15'h0000, s}, {15'h0000, v});
      tally_and_finish();
    end
  endtask

  task automatic wreg(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rreg(input logic [4:0] a, output logic [15:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic pulse_step();
    @(posedge clk);
    step <= 1'b1;
    @(posedge clk);
    step <= 1'b0;
  endtask

  // one-cycle pulse on the external clock and clear pins
  task automatic pulse_ext(input logic [2:0] which);
    @(posedge clk);
    ext_in <= which;
    @(posedge clk);
    ext_in <= 3'h0;
  endtask

  // reset values and an unmapped index
  task automatic sc_reset();
    rreg(5'h00, d);
    chk(d, 16'h0000);
    rreg(5'h07, d);
    chk(d, 16'hffff);
    rreg(5'h1f, d);
    chk(d, 16'h0000);
    chk({10'h000, poe_n}, 16'h003f);
  endtask

  // captures on both edges with the counter frozen
  task automatic sc_capture();
    wreg(5'h00, 16'h1234);
    wreg(5'h04, 16'h000e);
    wreg(5'h05, 16'h00a8);
    wreg(5'h02, 16'h0000);
    wreg(5'h03, 16'h0004);
    pulse_step();
    wait_lvl(tirq, 1'b1, n);
    rreg(5'h08, d);
    chk(d, 16'h1234);
    rreg(5'h02, d);
    chk(d, 16'h0004);
    wreg(5'h02, 16'h0000);
    pulse_step();
    repeat (4) @(posedge clk);
    #1;
    chk({15'h0000, tirq}, 16'h0000);
    rreg(5'h07, d);
    chk(d, 16'h1234);
    rreg(5'h02, d);
    chk(d, 16'h0002);
  endtask

  // compare match a across the counter wrap
  task automatic sc_compare();
    wreg(5'h00, 16'hfffe);
    wreg(5'h06, 16'h0001);
    wreg(5'h02, 16'h0000);
    wreg(5'h03, 16'h0001);
    wreg(5'h01, 16'h0080);
    wait_lvl(tirq, 1'b1, n);
    wreg(5'h01, 16'h0000);
    rreg(5'h02, d);
    chk(d, 16'h0001);
    rreg(5'h00, d);
    chk({3'h0, d[15:3]}, 16'h0000);
  endtask

  // open-loop start paced by compare a, then steps only on captures
  task automatic sc_startup();
    time t0;
    logic [5:0] ph;
    t0 = 0;
    wreg(5'h11, 16'h003f);
    wreg(5'h00, 16'h0000);
    wreg(5'h06, 16'h0003);
    wreg(5'h02, 16'h0000);
    wreg(5'h03, 16'h0001);
    wreg(5'h01, 16'h0086);
    for (int k = 0; k < 6; k++) begin
      wait_lvl(tirq, 1'b1, n);
      if (k > 0) begin
        chk(16'(($time - t0) / 8), 16'h0020);
      end
      t0 = $time;
      ph = 6'h01 << k;
      wreg(5'h02, 16'h0000);
      wreg(5'h10, {10'h000, ph});
      #1;
      chk({10'h000, pout}, {10'h000, ph});
      pulse_step();
    end
    wreg(5'h02, 16'h0000);
    wreg(5'h03, 16'h000e);
    #1;
    chk({15'h0000, tirq}, 16'h0000);
    pulse_step();
    wait_lvl(tirq, 1'b1, n);
    rreg(5'h02, d);
    chk(d & 16'h000e, 16'h0008);
    wreg(5'h01, 16'h0000);
  endtask

  // external clock sources and the external chopping clear
  task automatic sc_ext();
    wreg(5'h00, 16'h0000);
    wreg(5'h01, 16'h0083);
    wreg(5'h0d, 16'h0018);
    wreg(5'h0a, 16'h0055);
    wreg(5'h0f, 16'h0001);
    wreg(5'h0d, 16'h0019);
    repeat (3) pulse_ext(3'h3);
    rreg(5'h00, d);
    chk(d, 16'h0003);
    rreg(5'h0a, d);
    chk(d, 16'h0058);
    pulse_ext(3'h4);
    rreg(5'h0a, d);
    chk(d, 16'h0000);
    wreg(5'h01, 16'h0000);
  endtask

  // chopping wave, a clears and drives high, b drives low
  task automatic sc_chop();
    wreg(5'h0b, 16'h0008);
    wreg(5'h0c, 16'h0004);
    wreg(5'h0e, 16'h0018);
    wreg(5'h0f, 16'h0000);
    wreg(5'h0d, 16'h0069);
    wait_lvl(wave, 1'b0, n);
    wait_lvl(wave, 1'b1, n);
    wait_lvl(wave, 1'b0, n);
    chk(16'(n), 16'h000a);
    wait_lvl(wave, 1'b1, n);
    chk(16'(n), 16'h0008);
    chk({15'h0000, cirq}, 16'h0001);
    rreg(5'h0e, d);
    chk(d & 16'h003f, 16'h001b);
  endtask

  // port outputs and mixed direction read back
  task automatic sc_port();
    @(posedge clk);
    float_lvl <= 6'h10;
    wreg(5'h10, 16'h003f);
    wreg(5'h11, 16'h0005);
    #1;
    chk({10'h000, poe_n}, 16'h003a);
    chk({10'h000, pout}, 16'h003f);
    rreg(5'h10, d);
    chk(d & 16'h003f, 16'h0015);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    sc_reset();
    sc_capture();
    sc_compare();
    sc_startup();
    sc_chop();
    sc_ext();
    sc_port();
    tally_and_finish();
  end
endmodule // test_bldc_commutation_timers
